/* hw/pec_top.sv */
// Purpose: edge change interrupt logic for port A pins 5-0 and port B pins 7-4
// Assumes: pins are asynchronous to aclk; AXI4-Lite master on aclk
// Notes: flags are cleared by writing zero; set always beats clear
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps

// Functional notes
// - six writable rising-edge enables for port A pins 5-0
// - six writable falling-edge enables for port A pins 5-0
// - four writable rising-edge enables for port B pins 7-4
// - four writable falling-edge enables for port B pins 7-4
// - port A flag sets on an enabled rising or falling edge
// - port B flag sets on an enabled rising or falling edge
// - any flag set by an edge also sets the aggregate flag
// - with both enables clear a pin never sets its flag
// - flags set only by hardware; software clears by writing zero
// - every enable and flag bit resets to zero on any reset
// - unimplemented bits read zero and ignore writes
// - flag registers are software read/write-zero-to-clear plus hardware set
// - detection and flags continue when master enable is clear
// - aggregate flag is the OR of all per-pin flags
// - an edge during a clearing write leaves the flag set
// - with master enable set an enabled edge wakes the device
module pec_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] porta_pin,
  input wire logic [3:0] portb_pin,
  output logic change_irq_request,
  output logic wake,
  output logic irq
);

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  logic [pec_pkg::NPIN-1:0] pin_in;
  logic [pec_pkg::NPIN-1:0] sync1;
  logic [pec_pkg::NPIN-1:0] sync2;
  logic [pec_pkg::NPIN-1:0] sync3;
  logic [pec_pkg::NPIN-1:0] level;
  logic [pec_pkg::NPIN-1:0] next_level;
  logic [pec_pkg::NPIN-1:0] rise;
  logic [pec_pkg::NPIN-1:0] fall;

  assign pin_in = {portb_pin, porta_pin};

  genvar gi;
  generate
    for (gi = 0; gi < pec_pkg::NPIN; gi++)
    begin : g_pin
      // level follows once the second and third stages agree
      always_comb
      begin
        next_level[gi] = level[gi];
        if (sync2[gi] == sync3[gi])
        begin
          next_level[gi] = sync3[gi];
        end
        rise[gi] = next_level[gi] & ~level[gi];
        fall[gi] = ~next_level[gi] & level[gi];
      end
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          level[gi] <= 1'b0;
        end
        else if (clk_en)
        begin
          sync1[gi] <= pin_in[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          level[gi] <= next_level[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [5:0] porta_rise_enable;
  logic [5:0] porta_fall_enable;
  logic [5:0] porta_change_flags;
  logic [3:0] portb_rise_enable;
  logic [3:0] portb_fall_enable;
  logic [3:0] portb_change_flags;
  logic change_irq_master_enable;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [5:0] next_porta_rise_enable;
  logic [5:0] next_porta_fall_enable;
  logic [5:0] next_porta_change_flags;
  logic [3:0] next_portb_rise_enable;
  logic [3:0] next_portb_fall_enable;
  logic [3:0] next_portb_change_flags;
  logic next_change_irq_master_enable;
  logic [1:0] next_irq_status;
  logic [1:0] next_irq_mask;
  logic [5:0] set_a;
  logic [3:0] set_b;
  logic change_irq_aggregate_flag;

  // ****************************************************************
  // bus slave state
  // ****************************************************************
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic [1:0] bresp;
  logic bvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic next_aw_held;
  logic next_w_held;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic next_w_lane0;
  logic [1:0] next_bresp;
  logic next_bvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;
  logic wr_go;
  logic wr_hit;
  logic [7:0] wd;
  logic [7:0] rd_byte;
  logic rd_hit;

  assign s_axi_awready = clk_en & ~aw_held & ~bvalid;
  assign s_axi_wready = clk_en & ~w_held & ~bvalid;
  assign s_axi_arready = clk_en & ~rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // enabled edge detection per pin
  assign set_a = (rise[5:0] & porta_rise_enable)
    | (fall[5:0] & porta_fall_enable);
  assign set_b = (rise[9:6] & portb_rise_enable)
    | (fall[9:6] & portb_fall_enable);
  assign change_irq_aggregate_flag = |porta_change_flags
    | |portb_change_flags;
  assign change_irq_request = change_irq_aggregate_flag
    & change_irq_master_enable;
  assign irq = |(irq_status & irq_mask);

  always_comb
  begin
    wr_go = aw_held & w_held & ~bvalid;
    wr_hit = 1'b1;
    wd = w_data[7:0];
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bresp = bresp;
    next_bvalid = bvalid;
    next_porta_rise_enable = porta_rise_enable;
    next_porta_fall_enable = porta_fall_enable;
    next_portb_rise_enable = portb_rise_enable;
    next_portb_fall_enable = portb_fall_enable;
    next_change_irq_master_enable = change_irq_master_enable;
    next_irq_mask = irq_mask;
    next_porta_change_flags = porta_change_flags;
    next_portb_change_flags = portb_change_flags;
    next_irq_status = irq_status;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (wr_go)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      case ({aw_addr[7:2], 2'b00})
        pec_pkg::PORTA_RISE_OFS: next_porta_rise_enable = wd[5:0];
        pec_pkg::PORTA_FALL_OFS: next_porta_fall_enable = wd[5:0];
        pec_pkg::PORTA_FLAG_OFS: next_porta_change_flags = porta_change_flags & wd[5:0];
        pec_pkg::PORTB_RISE_OFS: next_portb_rise_enable = wd[7:4];
        pec_pkg::PORTB_FALL_OFS: next_portb_fall_enable = wd[7:4];
        pec_pkg::PORTB_FLAG_OFS: next_portb_change_flags = portb_change_flags & wd[7:4];
        pec_pkg::INTCTL_OFS: next_change_irq_master_enable = wd[pec_pkg::MASTER_EN_BIT];
        pec_pkg::IRQ_STATUS_OFS: next_irq_status = irq_status & ~wd[1:0];
        pec_pkg::IRQ_MASK_OFS: next_irq_mask = wd[1:0];
        default: wr_hit = 1'b0;
      endcase
      // a write without lane 0 leaves every register as it was
      if (!w_lane0)
      begin
        next_porta_rise_enable = porta_rise_enable;
        next_porta_fall_enable = porta_fall_enable;
        next_portb_rise_enable = portb_rise_enable;
        next_portb_fall_enable = portb_fall_enable;
        next_change_irq_master_enable = change_irq_master_enable;
        next_irq_mask = irq_mask;
        next_porta_change_flags = porta_change_flags;
        next_portb_change_flags = portb_change_flags;
        next_irq_status = irq_status;
      end
      next_bresp = wr_hit ? pec_pkg::RESP_OKAY : pec_pkg::RESP_SLVERR;
    end
    if (bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    // hardware set wins over a clearing write
    next_porta_change_flags = next_porta_change_flags | set_a;
    next_portb_change_flags = next_portb_change_flags | set_b;
    next_irq_status[pec_pkg::EVT_PORTA_BIT] = next_irq_status[pec_pkg::EVT_PORTA_BIT] | (|set_a);
    next_irq_status[pec_pkg::EVT_PORTB_BIT] = next_irq_status[pec_pkg::EVT_PORTB_BIT] | (|set_b);
  end

  // wake pulse is aligned with the edge at which the flags take the set
  always_comb
  begin
    wake = change_irq_master_enable & ((|set_a) | (|set_b));
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb
  begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    case ({s_axi_araddr[7:2], 2'b00})
      pec_pkg::PORTA_RISE_OFS: rd_byte = {2'b00, porta_rise_enable};
      pec_pkg::PORTA_FALL_OFS: rd_byte = {2'b00, porta_fall_enable};
      pec_pkg::PORTA_FLAG_OFS: rd_byte = {2'b00, porta_change_flags};
      pec_pkg::PORTB_RISE_OFS: rd_byte = {portb_rise_enable, 4'h0};
      pec_pkg::PORTB_FALL_OFS: rd_byte = {portb_fall_enable, 4'h0};
      pec_pkg::PORTB_FLAG_OFS: rd_byte = {portb_change_flags, 4'h0};
      pec_pkg::INTCTL_OFS:
      begin
        rd_byte[pec_pkg::MASTER_EN_BIT] = change_irq_master_enable;
        rd_byte[pec_pkg::AGG_FLAG_BIT] = change_irq_aggregate_flag;
      end
      pec_pkg::IRQ_STATUS_OFS: rd_byte = {6'h00, irq_status};
      pec_pkg::IRQ_MASK_OFS: rd_byte = {6'h00, irq_mask};
      default: rd_hit = 1'b0;
    endcase
    next_rdata = rdata;
    next_rresp = rresp;
    next_rvalid = rvalid;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rdata = {24'h000000, rd_byte};
      next_rresp = rd_hit ? pec_pkg::RESP_OKAY : pec_pkg::RESP_SLVERR;
      next_rvalid = 1'b1;
    end
    else if (rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  // ****************************************************************
  // state registers
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      porta_rise_enable <= pec_pkg::PORTA_RST;
      porta_fall_enable <= pec_pkg::PORTA_RST;
      porta_change_flags <= pec_pkg::PORTA_RST;
      portb_rise_enable <= pec_pkg::PORTB_RST;
      portb_fall_enable <= pec_pkg::PORTB_RST;
      portb_change_flags <= pec_pkg::PORTB_RST;
      change_irq_master_enable <= pec_pkg::MASTER_EN_RST;
      irq_status <= pec_pkg::EVT_RST;
      irq_mask <= pec_pkg::EVT_RST;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_lane0 <= 1'b0;
      bresp <= pec_pkg::RESP_OKAY;
      bvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= pec_pkg::RESP_OKAY;
      rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      porta_rise_enable <= next_porta_rise_enable;
      porta_fall_enable <= next_porta_fall_enable;
      porta_change_flags <= next_porta_change_flags;
      portb_rise_enable <= next_portb_rise_enable;
      portb_fall_enable <= next_portb_fall_enable;
      portb_change_flags <= next_portb_change_flags;
      change_irq_master_enable <= next_change_irq_master_enable;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      bresp <= next_bresp;
      bvalid <= next_bvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      rvalid <= next_rvalid;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_A_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && |set_a |=> (porta_change_flags & $past(set_a)) == $past(set_a))
    else $error("port A edge did not set its flag");
  AST_B_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && |set_b |=> (portb_change_flags & $past(set_b)) == $past(set_b))
    else $error("port B edge did not set its flag");
  AST_AGG: assert property (@(posedge aclk) disable iff (!aresetn)
    change_irq_aggregate_flag == ((porta_change_flags != 6'h00)
    || (portb_change_flags != 4'h0)))
    else $error("aggregate flag differs from per-pin flags");
  AST_NO_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && porta_rise_enable == 6'h00 && porta_fall_enable == 6'h00
    && !wr_go |=> (porta_change_flags & ~$past(porta_change_flags)) == 6'h00)
    else $error("disabled port A pin set a flag");
  AST_HOLD_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !porta_change_flags[0] && !set_a[0] |=> !porta_change_flags[0])
    else $error("cleared flag rose without an edge");
  AST_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && wr_go && set_a[0] |=> porta_change_flags[0])
    else $error("clearing write lost an edge");
  AST_REQ: assert property (@(posedge aclk) disable iff (!aresetn)
    change_irq_request == (change_irq_master_enable && change_irq_aggregate_flag))
    else $error("request does not follow flag and enable");
  AST_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && wake |=> change_irq_aggregate_flag)
    else $error("wake without updated flags");
  AST_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && sync2[0] && sync3[0] && !level[0] |-> rise[0] ##1 level[0])
    else $error("stable high input missed its rising edge");
  AST_RESET: assert property (@(posedge aclk)
    !aresetn |=> porta_rise_enable == 6'h00 && portb_change_flags == 4'h0)
    else $error("register not cleared by reset");

endmodule : pec_top

/* include/pec_pkg.sv */
// Purpose: constants for the pin edge change interrupt block
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes: all registers clear on every reset
package pec_pkg;
  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] PORTA_RISE_OFS = 8'h00;
  localparam logic [7:0] PORTA_FALL_OFS = 8'h04;
  localparam logic [7:0] PORTA_FLAG_OFS = 8'h08;
  localparam logic [7:0] PORTB_RISE_OFS = 8'h0c;
  localparam logic [7:0] PORTB_FALL_OFS = 8'h10;
  localparam logic [7:0] PORTB_FLAG_OFS = 8'h14;
  localparam logic [7:0] INTCTL_OFS = 8'h18;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h1c;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h20;
  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int PORTA_LSB = 0;
  localparam int PORTA_W = 6;
  localparam int PORTB_LSB = 4;
  localparam int PORTB_W = 4;
  localparam int NPIN = 10;
  localparam int MASTER_EN_BIT = 4;
  localparam int AGG_FLAG_BIT = 0;
  localparam int EVT_PORTA_BIT = 0;
  localparam int EVT_PORTB_BIT = 1;
  localparam int EVT_W = 2;
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [5:0] PORTA_RST = 6'h00;
  localparam logic [3:0] PORTB_RST = 4'h0;
  localparam logic [1:0] EVT_RST = 2'h0;
  localparam logic MASTER_EN_RST = 1'b0;
  // ****************************************************************
  // bus answers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pec_pkg

/* testbench/pec_pin_model.sv */
// Purpose: far side of the edge change block: port pins and the wake listener
// Assumes: pins are plain levels with no pull, driven by this model alone
// Notes: levels move 7 ns after each rising aclk edge, so they keep a fixed phase to aclk and never change on its edges
`timescale 1ns/10ps
module pec_pin_model (
  input wire logic aclk,
  input wire logic [5:0] pa_req,
  input wire logic [3:0] pb_req,
  input wire logic wake,
  output logic [5:0] porta_pin,
  output logic [3:0] portb_pin,
  output logic [15:0] wake_cnt
);
  initial
  begin
    porta_pin = 6'h00;
    portb_pin = 4'h0;
    wake_cnt = 16'h0000;
  end
  // a new level lands well away from the sampling edge
  always @(posedge aclk)
  begin
    #7;
    porta_pin = pa_req;
    portb_pin = pb_req;
  end
  // processor side counts each wake-up request, sampled mid-cycle
  always @(negedge aclk)
    if (wake === 1'b1)
      wake_cnt <= wake_cnt + 16'h0001;
endmodule : pec_pin_model

/* testbench/tb_top.sv */
// Purpose: self-checking bench for the edge change interrupt block
// Assumes: AXI4-Lite master with bready and rready held high
// Notes: expected bus answers queue up and are compared by a monitor
`timescale 1ns/10ps
module tb_top;
  localparam logic [1:0] OK = pec_pkg::RESP_OKAY;
  localparam logic [7:0] OFS_TAB [9] = '{pec_pkg::PORTA_RISE_OFS, pec_pkg::PORTA_FALL_OFS,
    pec_pkg::PORTA_FLAG_OFS, pec_pkg::PORTB_RISE_OFS, pec_pkg::PORTB_FALL_OFS,
    pec_pkg::PORTB_FLAG_OFS, pec_pkg::INTCTL_OFS, pec_pkg::IRQ_STATUS_OFS, pec_pkg::IRQ_MASK_OFS};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, r;
  wire logic awready, wready, bvalid, arready, rvalid, irq_o, req_o, wake_o;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [5:0] porta_pin;
  wire logic [3:0] portb_pin;
  wire logic [15:0] wake_cnt;
  logic [5:0] pa_req, ra, fa, flag_a, ea;
  logic [3:0] pb_req, rb, fb, flag_b, eb;
  logic [1:0] st, mk;
  logic men;
  logic [15:0] w0;
  logic [34:0] exp_q [$];
  logic [34:0] mon_e;
  int num_errors = 0;
  int n_checks = 0;
  int seed = 32'h1657ef38;

  pec_top dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .porta_pin(porta_pin),
    .portb_pin(portb_pin), .change_irq_request(req_o), .wake(wake_o), .irq(irq_o));
  pec_pin_model pins (.aclk(aclk), .pa_req(pa_req), .pb_req(pb_req), .wake(wake_o),
    .porta_pin(porta_pin), .portb_pin(portb_pin), .wake_cnt(wake_cnt));

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ****************************************************************
  // checking
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("Checks made: %0d, mismatches: %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  always @(negedge aclk)
  begin
    if ((bvalid === 1'b1 && bready) || (rvalid === 1'b1 && rready))
    begin
      if (exp_q.size() == 0)
        chk(32'h1, 32'h0);
      else
      begin
        mon_e = exp_q.pop_front();
        chk({30'h0, (bvalid === 1'b1) ? bresp : rresp}, {30'h0, mon_e[33:32]});
        if (mon_e[34])
          chk(rdata, mon_e[31:0]);
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    chk(32'h1, 32'h0);
    conclude();
  end

  // ****************************************************************
  // bus master and expectations
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ahs, whs, got;
    got = 1'b0;
    exp_q.push_back({1'b0, er, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!got)
    begin
      @(negedge aclk);
      ahs = awvalid && awready;
      whs = wvalid && wready;
      got = (bvalid === 1'b1);
      @(posedge aclk);
      if (ahs)
        awvalid <= 1'b0;
      if (whs)
        wvalid <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ahs, got;
    got = 1'b0;
    exp_q.push_back({1'b1, er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    while (!got)
    begin
      @(negedge aclk);
      ahs = arvalid && arready;
      got = (rvalid === 1'b1);
      @(posedge aclk);
      if (ahs)
        arvalid <= 1'b0;
    end
  endtask : rd

  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      pec_pkg::PORTA_RISE_OFS: v[5:0] = ra;
      pec_pkg::PORTA_FALL_OFS: v[5:0] = fa;
      pec_pkg::PORTA_FLAG_OFS: v[5:0] = flag_a;
      pec_pkg::PORTB_RISE_OFS: v[7:4] = rb;
      pec_pkg::PORTB_FALL_OFS: v[7:4] = fb;
      pec_pkg::PORTB_FLAG_OFS: v[7:4] = flag_b;
      pec_pkg::INTCTL_OFS: v = {27'h0, men, 3'h0, |{flag_a, flag_b}};
      pec_pkg::IRQ_STATUS_OFS: v[1:0] = st;
      pec_pkg::IRQ_MASK_OFS: v[1:0] = mk;
      default: v = 32'h0;
    endcase
    return v;
  endfunction : exp_rd

  task automatic clear_model;
    {ra, fa, flag_a, rb, fb, flag_b, st, mk, men} = 35'h0;
  endtask : clear_model

  task automatic check_all;
    for (int k = 0; k < 9; k++)
      rd(OFS_TAB[k], exp_rd(OFS_TAB[k]), OK);
    @(negedge aclk);
    chk({31'h0, req_o}, {31'h0, (|{flag_a, flag_b}) & men});
    chk({31'h0, irq_o}, {31'h0, |(st & mk)});
    @(posedge aclk);
  endtask : check_all

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = 52'h0;
    bready = 1'b1;
    rready = 1'b1;
    pa_req = 6'h00;
    pb_req = 4'h0;
    clear_model();
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    tick(1);
    check_all();
    rd(8'h24, 32'h0, pec_pkg::RESP_SLVERR);
    wr(8'h3c, 32'hffffffff, pec_pkg::RESP_SLVERR);
    check_all();
    for (int i = 0; i < 24; i++)
    begin
      r = $random(seed);
      ra = r[5:0];
      wr(pec_pkg::PORTA_RISE_OFS, r, OK);
      r = $random(seed);
      fa = r[5:0];
      wr(pec_pkg::PORTA_FALL_OFS, r, OK);
      r = $random(seed);
      rb = r[7:4];
      wr(pec_pkg::PORTB_RISE_OFS, r, OK);
      r = $random(seed);
      fb = r[7:4];
      wr(pec_pkg::PORTB_FALL_OFS, r, OK);
      r = $random(seed);
      men = r[4];
      wr(pec_pkg::INTCTL_OFS, r, OK);
      r = $random(seed);
      mk = r[1:0];
      wr(pec_pkg::IRQ_MASK_OFS, r, OK);
      check_all();
      r = $random(seed);
      ea = (~pa_req & r[5:0] & ra) | (pa_req & ~r[5:0] & fa);
      eb = (~pb_req & r[9:6] & rb) | (pb_req & ~r[9:6] & fb);
      pa_req <= r[5:0];
      pb_req <= r[9:6];
      w0 = wake_cnt;
      tick(8);
      flag_a = flag_a | ea;
      flag_b = flag_b | eb;
      st = st | {|eb, |ea};
      chk({16'h0, wake_cnt - w0}, {31'h0, men & (|{ea, eb})});
      check_all();
      r = $random(seed);
      wr(pec_pkg::PORTA_FLAG_OFS, r, OK);
      flag_a = flag_a & r[5:0];
      wr(pec_pkg::PORTB_FLAG_OFS, r, OK);
      flag_b = flag_b & r[7:4];
      wr(pec_pkg::IRQ_STATUS_OFS, r, OK);
      st = st & ~r[1:0];
    end
    check_all();
    wr(pec_pkg::PORTA_RISE_OFS, 32'h3f, OK);
    wr(pec_pkg::PORTA_FALL_OFS, 32'h3f, OK);
    for (int d = 0; d < 7; d++)
      if (d < 3 || d == 6)
      begin
        wr(pec_pkg::PORTA_FLAG_OFS, 32'h0, OK);
        pa_req <= ~pa_req;
        tick(d);
        wr(pec_pkg::PORTA_FLAG_OFS, 32'h0, OK);
        tick(8);
        rd(pec_pkg::PORTA_FLAG_OFS, (d < 3) ? 32'h3f : 32'h0, OK);
      end
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    clear_model();
    tick(1);
    check_all();
    conclude();
  end
endmodule : tb_top
